// file: hdl/dpr_pkg.sv
// Types shared by the dual-port RAM port block.
// Assumes the register header is on the include path.
`include "dpr_regs.svh"
package dpr_pkg;
  typedef enum logic [0:0] {
    DPR_W_IDLE,
    DPR_W_RESP
  } dpr_wr_state_t;
  typedef logic [1:0] dpr_resp_t;
endpackage

// file: hdl/dpr_port_ram.sv
// Two synchronous RAM ports on one array, plus an AXI4-Lite register slave.
// Assumes both ports and the bus run on clk_in; data pins are split into
// in, out and output enable; the bench resolves the shared wires.
`timescale 1ns/1ns
`include "dpr_regs.svh"
`default_nettype none

// Function
// RULE1 - Inputs registered on clock edge, write self-timed
// RULE2 - Output enable gates drivers without clocking
// RULE3 - Strobe low loads external address
// RULE4 - Access address external or counter by strobe
// RULE5 - Counter advance steps address by one
// RULE6 - Strobe and advance high hold address
// RULE7 - Counter clear accesses address zero immediately
// RULE8 - Deselect for one cycle enters standby
// RULE9 - Pipelined outputs need two selected cycles; the code drives only after the third selected edge
// RULE10 - Pipelined output state from previous controls
// RULE11 - Master rewrites data after idle turnaround
// RULE12 - Flow-through cross-port read after write delay
// RULE13 - Pipelined cross-port read one cycle later
// RULE14 - Both ports identical, either writes or reads
// RULE15 - Latency select held static by master
// RULE16 - Deselected byte lane floats on read
// RULE17 - Deselect floats outputs after next edge
// RULE18 - Write updates only selected byte lanes
module dpr_port_ram #(
  parameter int ADDR_W = 15,
  parameter int DEPTH = 32768
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic [ADDR_W-1:0] a_addr_in,
  input wire logic [15:0] a_data_in,
  output logic [15:0] a_data_out,
  output logic [15:0] a_data_oe_out,
  input wire logic a_read_write_n_in,
  input wire logic a_output_enable_n_in,
  input wire logic a_address_strobe_n_in,
  input wire logic a_counter_advance_n_in,
  input wire logic a_counter_clear_n_in,
  input wire logic a_primary_select_n_in,
  input wire logic a_secondary_select_in,
  input wire logic a_upper_lane_select_n_in,
  input wire logic a_lower_lane_select_n_in,
  input wire logic a_output_latency_select_in,
  output logic a_standby_out,
  input wire logic [ADDR_W-1:0] b_addr_in,
  input wire logic [15:0] b_data_in,
  output logic [15:0] b_data_out,
  output logic [15:0] b_data_oe_out,
  input wire logic b_read_write_n_in,
  input wire logic b_output_enable_n_in,
  input wire logic b_address_strobe_n_in,
  input wire logic b_counter_advance_n_in,
  input wire logic b_counter_clear_n_in,
  input wire logic b_primary_select_n_in,
  input wire logic b_secondary_select_in,
  input wire logic b_upper_lane_select_n_in,
  input wire logic b_lower_lane_select_n_in,
  input wire logic b_output_latency_select_in,
  output logic b_standby_out,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  logic [15:0] mem [DEPTH];
  logic [31:0] ctrl;
  logic [1:0] sel, rw_n, oe_n, strobe_n, adv_n, clr_n, lat;
  logic [1:0] act_q, act_p, sel_q, sel_qq, standby, drive;
  logic [1:0] lanes_n [2], lane_q [2], lane_p [2], lane_on [2];
  logic [ADDR_W-1:0] ext_addr [2], cnt [2], next_addr [2];
  logic [15:0] wdata [2], flow_data [2], pipe_data [2];

  function automatic logic [ADDR_W-1:0] dpr_step(
    input logic clear_n,
    input logic load_n,
    input logic step_n,
    input logic [ADDR_W-1:0] ext,
    input logic [ADDR_W-1:0] cur
  );
    logic [ADDR_W-1:0] res;
    res = cur;
    if (!clear_n) begin
      res = '0;
    end else if (!load_n) begin
      res = ext;
    end else if (!step_n) begin
      res = ADDR_W'(cur + 1'h1);
    end
    return res;
  endfunction

  function automatic logic [31:0] dpr_stat(
    input logic [ADDR_W-1:0] addr,
    input logic sb,
    input logic drv
  );
    logic [31:0] res;
    res = '0;
    res[ADDR_W-1:0] = addr;
    res[`DPR_STAT_STANDBY_BIT] = sb;
    res[`DPR_STAT_DRIVE_BIT] = drv;
    return res;
  endfunction

  // Both ports gather into arrays so one body serves each side
  assign sel[0] = !a_primary_select_n_in && a_secondary_select_in &&
                  ctrl[`DPR_CTRL_A_EN_BIT];
  assign sel[1] = !b_primary_select_n_in && b_secondary_select_in &&
                  ctrl[`DPR_CTRL_B_EN_BIT];
  assign rw_n = {b_read_write_n_in, a_read_write_n_in};
  assign oe_n = {b_output_enable_n_in, a_output_enable_n_in};
  assign strobe_n = {b_address_strobe_n_in, a_address_strobe_n_in};
  assign adv_n = {b_counter_advance_n_in, a_counter_advance_n_in};
  assign clr_n = {b_counter_clear_n_in, a_counter_clear_n_in};
  assign lat = {b_output_latency_select_in, a_output_latency_select_in};
  assign lanes_n[0] = {a_upper_lane_select_n_in, a_lower_lane_select_n_in};
  assign lanes_n[1] = {b_upper_lane_select_n_in, b_lower_lane_select_n_in};
  assign ext_addr[0] = a_addr_in;
  assign ext_addr[1] = b_addr_in;
  assign wdata[0] = a_data_in;
  assign wdata[1] = b_data_in;

  always_comb begin
    for (int p = 0; p < 2; p++) begin
      next_addr[p] = dpr_step(clr_n[p], strobe_n[p], adv_n[p],
                              ext_addr[p], cnt[p]); // RULE4 RULE7
    end
  end

  // Address counter and registered read path of each port
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      for (int p = 0; p < 2; p++) begin
        cnt[p] <= '0;
        flow_data[p] <= '0;
        pipe_data[p] <= '0;
        lane_q[p] <= '0;
        lane_p[p] <= '0;
      end
      act_q <= '0;
      act_p <= '0;
      sel_q <= '0;
      sel_qq <= '0;
      standby <= 2'h3;
    end else if (ce_in) begin
      for (int p = 0; p < 2; p++) begin // RULE14
        cnt[p] <= next_addr[p]; // RULE3 RULE5 RULE6
        if (sel[p]) begin
          flow_data[p] <= mem[next_addr[p]]; // RULE1
        end
        pipe_data[p] <= flow_data[p];
        lane_q[p] <= ~lanes_n[p] & {2{sel[p] && rw_n[p]}}; // RULE16
        lane_p[p] <= lane_q[p];
      end
      act_q <= sel & rw_n;
      act_p <= act_q & sel_qq; // RULE9 RULE10
      sel_q <= sel;
      sel_qq <= sel_q;
      standby <= ~sel; // RULE8
    end
  end

  // Writes land at the edge; a same-edge read on the other port sees
  // old data, so cross-port data shows one access later. Port B wins
  // a same-address collision.
  always_ff @(posedge clk_in) begin
    if (ce_in && !rst_in) begin
      for (int p = 0; p < 2; p++) begin
        if (sel[p] && !rw_n[p]) begin // RULE12 RULE13
          if (!lanes_n[p][0]) begin
            mem[next_addr[p]][7:0] <= wdata[p][7:0]; // RULE18
          end
          if (!lanes_n[p][1]) begin
            mem[next_addr[p]][15:8] <= wdata[p][15:8]; // RULE18
          end
        end
      end
    end
  end

  always_comb begin
    for (int p = 0; p < 2; p++) begin
      // Pipelined drive also needs the latest select so a deselect
      // floats the pins right after its edge
      drive[p] = lat[p] ? (act_p[p] && sel_q[p]) : act_q[p]; // RULE17
      lane_on[p] = lat[p] ? lane_p[p] : lane_q[p];
    end
  end

  assign a_data_out = lat[0] ? pipe_data[0] : flow_data[0];
  assign b_data_out = lat[1] ? pipe_data[1] : flow_data[1];
  assign a_data_oe_out = {{8{drive[0] && lane_on[0][1] && !oe_n[0]}},
                          {8{drive[0] && lane_on[0][0] && !oe_n[0]}}}; // RULE2
  assign b_data_oe_out = {{8{drive[1] && lane_on[1][1] && !oe_n[1]}},
                          {8{drive[1] && lane_on[1][0] && !oe_n[1]}}}; // RULE2
  assign a_standby_out = standby[0];
  assign b_standby_out = standby[1];

  // AXI4-Lite write side: address and data taken in either order
  dpr_pkg::dpr_wr_state_t wr_state;
  logic aw_got;
  logic w_got;
  logic [`DPR_ADDR_DEC_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  dpr_pkg::dpr_resp_t b_resp;

  assign s_axi_awready = ce_in && !aw_got &&
                         wr_state == dpr_pkg::DPR_W_IDLE;
  assign s_axi_wready = ce_in && !w_got && wr_state == dpr_pkg::DPR_W_IDLE;
  assign s_axi_bvalid = wr_state == dpr_pkg::DPR_W_RESP;
  assign s_axi_bresp = b_resp;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wr_state <= dpr_pkg::DPR_W_IDLE;
      aw_got <= 1'h0;
      w_got <= 1'h0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      b_resp <= `DPR_RESP_OKAY;
      ctrl <= `DPR_CTRL_RESET;
    end else if (ce_in) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got <= 1'h1;
        aw_addr <= s_axi_awaddr[`DPR_ADDR_DEC_W-1:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got <= 1'h1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      case (wr_state)
        dpr_pkg::DPR_W_IDLE: begin
          if (aw_got && w_got) begin
            aw_got <= 1'h0;
            w_got <= 1'h0;
            wr_state <= dpr_pkg::DPR_W_RESP;
            if (aw_addr == `DPR_CTRL_OFFSET) begin
              b_resp <= `DPR_RESP_OKAY;
              if (w_strb[0]) begin
                ctrl[1:0] <= w_data[1:0];
              end
            end else if (aw_addr == `DPR_STAT_A_OFFSET ||
                         aw_addr == `DPR_STAT_B_OFFSET) begin
              b_resp <= `DPR_RESP_OKAY;
            end else begin
              b_resp <= `DPR_RESP_SLVERR;
            end
          end
        end
        dpr_pkg::DPR_W_RESP: begin
          if (s_axi_bready) begin
            wr_state <= dpr_pkg::DPR_W_IDLE;
          end
        end
        default: begin
          wr_state <= dpr_pkg::DPR_W_IDLE;
        end
      endcase
    end
  end

  // AXI4-Lite read side: one read at a time, answer one edge later
  logic r_valid;
  logic [31:0] r_data;
  dpr_pkg::dpr_resp_t r_resp;

  assign s_axi_arready = ce_in && !r_valid;
  assign s_axi_rvalid = r_valid;
  assign s_axi_rdata = r_data;
  assign s_axi_rresp = r_resp;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      r_valid <= 1'h0;
      r_data <= '0;
      r_resp <= `DPR_RESP_OKAY;
    end else if (ce_in) begin
      if (r_valid && s_axi_rready) begin
        r_valid <= 1'h0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        r_valid <= 1'h1;
        r_resp <= `DPR_RESP_OKAY;
        case (s_axi_araddr[`DPR_ADDR_DEC_W-1:0])
          `DPR_CTRL_OFFSET: r_data <= {30'h0, ctrl[1:0]};
          `DPR_STAT_A_OFFSET: r_data <= dpr_stat(cnt[0], standby[0], drive[0]);
          `DPR_STAT_B_OFFSET: r_data <= dpr_stat(cnt[1], standby[1], drive[1]);
          default: begin
            r_data <= '0;
            r_resp <= `DPR_RESP_SLVERR;
          end
        endcase
      end
    end
  end

  a_addr_load: assert property (@(posedge clk_in) disable iff (rst_in) // RULE3
    ce_in && a_counter_clear_n_in && !a_address_strobe_n_in
    |=> cnt[0] == $past(a_addr_in))
    else $error("strobe did not load address");

  a_access_ext: assert property (@(posedge clk_in) disable iff (rst_in) // RULE4
    a_counter_clear_n_in && !a_address_strobe_n_in
    |-> next_addr[0] == a_addr_in)
    else $error("access address not external");

  a_addr_step: assert property (@(posedge clk_in) disable iff (rst_in) // RULE5
    ce_in && a_counter_clear_n_in && a_address_strobe_n_in &&
    !a_counter_advance_n_in
    |=> cnt[0] == ADDR_W'($past(cnt[0]) + 1'h1))
    else $error("counter did not step by one");

  a_addr_hold: assert property (@(posedge clk_in) disable iff (rst_in) // RULE6
    ce_in && a_counter_clear_n_in && a_address_strobe_n_in &&
    a_counter_advance_n_in |=> $stable(cnt[0]))
    else $error("address moved while held");

  a_clear_zero: assert property (@(posedge clk_in) disable iff (rst_in) // RULE7
    ce_in && !a_counter_clear_n_in |-> next_addr[0] == '0 ##1 cnt[0] == '0)
    else $error("clear did not target zero");

  a_standby_set: assert property (@(posedge clk_in) disable iff (rst_in) // RULE8
    ce_in && !sel[1] |=> b_standby_out)
    else $error("deselect did not enter standby");

  a_pipe_wake: assert property (@(posedge clk_in) disable iff (rst_in) // RULE9
    ce_in && b_output_latency_select_in && !sel[1] ##1 ce_in && sel[1]
    |=> b_data_oe_out == 16'h0)
    else $error("pipelined output woke after one cycle");

  a_deselect_off: assert property (@(posedge clk_in) disable iff (rst_in) // RULE17
    ce_in && !sel[0] |=> a_data_oe_out == 16'h0)
    else $error("outputs driven after deselect");

  a_oe_float: assert property (@(posedge clk_in) disable iff (rst_in) // RULE2
    b_output_enable_n_in |-> b_data_oe_out == 16'h0)
    else $error("drivers on while output enable high");

  a_lane_float: assert property (@(posedge clk_in) disable iff (rst_in) // RULE16
    ce_in && !a_output_latency_select_in && a_upper_lane_select_n_in
    |=> a_data_oe_out[15:8] == 8'h0)
    else $error("upper lane driven while deselected");

endmodule
`default_nettype wire

// file: hdl/dpr_regs.svh
// Register offsets, field positions and reset values of the port block.
// Assumes inclusion by bare name from the package and the design.
`ifndef DPR_REGS_SVH
`define DPR_REGS_SVH
`define DPR_CTRL_OFFSET 12'h000
`define DPR_STAT_A_OFFSET 12'h004
`define DPR_STAT_B_OFFSET 12'h008
`define DPR_CTRL_RESET 32'h0000_0003
`define DPR_CTRL_A_EN_BIT 0
`define DPR_CTRL_B_EN_BIT 1
`define DPR_STAT_STANDBY_BIT 16
`define DPR_STAT_DRIVE_BIT 17
`define DPR_RESP_OKAY 2'h0
`define DPR_RESP_SLVERR 2'h2
`define DPR_ADDR_DEC_W 12
`endif

// file: test/dpr_port_bus.sv
// Bus-master side of one RAM data bus: resolves the shared data wire.
// Assumes the master drives data only while it writes.
`timescale 1ns/1ns
`default_nettype none
module dpr_port_bus #(
  parameter bit PIPED = 1'b0
) (
  input wire logic clk_in,
  input wire logic [15:0] dev_data_in,
  input wire logic [15:0] dev_oe_in,
  input wire logic [15:0] mst_data_in,
  input wire logic mst_drive_in,
  output logic [15:0] level_out,
  output logic latency_select_out
);
  // Undriven bits flip each cycle so stale data never reads as valid
  logic [15:0] last = 16'h0000;
  assign latency_select_out = PIPED;
  // Master drives only on writes, with output enable held off
  assign level_out = (dev_data_in & dev_oe_in) |
    ((mst_drive_in ? mst_data_in : ~last) & ~dev_oe_in);
  always_ff @(posedge clk_in) begin
    last <= level_out;
  end
endmodule
`default_nettype wire

// file: test/tb_dpr_port_ram.sv
// Testbench: port A flow-through, port B pipelined, registers on AXI.
// Assumes one clock for both ports and the register bus.
`timescale 1ns/1ns
`include "dpr_regs.svh"
`default_nettype none
module tb_dpr_port_ram;
  logic clk_in, rst_in, ce;
  logic [14:0] addr[2];
  logic [15:0] dout[2], oe[2], wl[2], mdat[2];
  logic rw[2], oen[2], address_strobe_n[2], adv[2], clr[2], sel[2], ul[2], ll[2];
  logic mdrv[2], lat[2], sb[2];
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [31:0] d;
  int fail_count = 0;
  int check_count = 0;
  dpr_port_ram dpr_port_ram_i (.clk_in, .rst_in, .ce_in(ce),
    .a_addr_in(addr[0]), .a_data_in(wl[0]), .a_data_out(dout[0]),
    .a_data_oe_out(oe[0]), .a_read_write_n_in(rw[0]),
    .a_output_enable_n_in(oen[0]), .a_address_strobe_n_in(address_strobe_n[0]),
    .a_counter_advance_n_in(adv[0]), .a_counter_clear_n_in(clr[0]),
    .a_primary_select_n_in(~sel[0]), .a_secondary_select_in(sel[0]),
    .a_upper_lane_select_n_in(ul[0]), .a_lower_lane_select_n_in(ll[0]),
    .a_output_latency_select_in(lat[0]), .a_standby_out(sb[0]),
    .b_addr_in(addr[1]), .b_data_in(wl[1]), .b_data_out(dout[1]),
    .b_data_oe_out(oe[1]), .b_read_write_n_in(rw[1]),
    .b_output_enable_n_in(oen[1]), .b_address_strobe_n_in(address_strobe_n[1]),
    .b_counter_advance_n_in(adv[1]), .b_counter_clear_n_in(clr[1]),
    .b_primary_select_n_in(~sel[1]), .b_secondary_select_in(sel[1]),
    .b_upper_lane_select_n_in(ul[1]), .b_lower_lane_select_n_in(ll[1]),
    .b_output_latency_select_in(lat[1]), .b_standby_out(sb[1]),
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  for (genvar g = 0; g < 2; g++) begin : g_bus
    dpr_port_bus #(.PIPED(g == 1)) dpr_port_bus_i (.clk_in,
      .dev_data_in(dout[g]), .dev_oe_in(oe[g]), .mst_data_in(mdat[g]),
      .mst_drive_in(mdrv[g]), .level_out(wl[g]),
      .latency_select_out(lat[g]));
  end
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task axi_wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge clk_in);
    s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_in);
      if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
      if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task axi_rd(input logic [31:0] a);
    @(posedge clk_in);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_in);
      if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata; r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task op(input int p, input logic rwn, sn, an, cn, input logic [1:0] ln,
      input logic [14:0] ad, input logic [15:0] v);
    @(posedge clk_in);
    rw[p] <= rwn; address_strobe_n[p] <= sn; adv[p] <= an; clr[p] <= cn;
    ul[p] <= ln[1]; ll[p] <= ln[0]; addr[p] <= ad; mdat[p] <= v;
    mdrv[p] <= ~rwn; oen[p] <= ~rwn;
  endtask
  task rd(input int p, input logic [14:0] ad);
    op(p, 1'b1, 1'b0, 1'b1, 1'b1, 2'b00, ad, 16'h0000);
  endtask
  task wr(input int p, input logic [14:0] ad, input logic [15:0] v);
    op(p, 1'b0, 1'b0, 1'b1, 1'b1, 2'b00, ad, v);
  endtask
  // Hold cycles double as the wait for output latency
  task look(input int p, input int n, input logic [15:0] e);
    repeat (n) op(p, 1'b1, 1'b1, 1'b1, 1'b1, 2'b00, 15'h0000, 16'h0000);
    #1 chk(wl[p], e);
  endtask
  initial begin
    rst_in = 1'b1;
    ce = 1'b1;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    for (int i = 0; i < 2; i++) begin
      addr[i] = 15'h0000; mdat[i] = 16'h0000; mdrv[i] = 1'b0;
      {rw[i], oen[i], address_strobe_n[i], adv[i], clr[i]} = 5'h1F;
      {sel[i], ul[i], ll[i]} = 3'h0;
    end
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    axi_rd({20'h0, `DPR_CTRL_OFFSET});
    chk(d, `DPR_CTRL_RESET);
    axi_rd({20'h0, `DPR_STAT_A_OFFSET});
    chk(d & 32'h0001_7FFF, 32'h0001_0000);
    axi_rd(32'h0000_000C);
    chk(r, `DPR_RESP_SLVERR);
    chk(d, 32'h0000_0000);
    $display("test registers done");
    @(posedge clk_in);
    sel[0] <= 1'b1; sel[1] <= 1'b1;
    wr(0, 15'h0005, 16'hA5C3);
    rd(0, 15'h0005);
    look(0, 1, 16'hA5C3);
    chk(oe[0], 16'hFFFF);
    op(0, 1'b0, 1'b0, 1'b1, 1'b1, 2'b01, 15'h0005, 16'h1234);
    op(0, 1'b1, 1'b0, 1'b1, 1'b1, 2'b00, 15'h0005, 16'h0000);
    look(0, 1, 16'h12C3);
    op(0, 1'b1, 1'b0, 1'b1, 1'b1, 2'b10, 15'h0005, 16'h0000);
    op(0, 1'b1, 1'b1, 1'b1, 1'b1, 2'b10, 15'h0000, 16'h0000);
    #1 chk(oe[0], 16'h00FF);
    $display("test lanes done");
    wr(0, 15'h000A, 16'h0010);
    op(0, 1'b0, 1'b1, 1'b0, 1'b1, 2'b00, 15'h0000, 16'h0011);
    op(0, 1'b0, 1'b1, 1'b0, 1'b1, 2'b00, 15'h0000, 16'h0012);
    for (int i = 0; i < 3; i++) begin
      rd(0, 15'(10 + i));
      look(0, 1, 16'(16 + i));
    end
    rd(0, 15'h000A);
    op(0, 1'b1, 1'b1, 1'b0, 1'b1, 2'b00, 15'h0000, 16'h0000);
    look(0, 1, 16'h0011);
    look(0, 3, 16'h0011);
    op(0, 1'b0, 1'b1, 1'b1, 1'b0, 2'b00, 15'h0000, 16'hBEEF);
    rd(0, 15'h000C);
    op(0, 1'b1, 1'b1, 1'b1, 1'b0, 2'b00, 15'h0000, 16'h0000);
    look(0, 1, 16'hBEEF);
    $display("test counter done");
    wr(0, 15'h0014, 16'h5A5A);
    rd(1, 15'h0014);
    look(1, 2, 16'h5A5A);
    wr(1, 15'h0015, 16'hC3C3);
    rd(0, 15'h0015);
    look(0, 1, 16'hC3C3);
    look(1, 3, 16'hC3C3);
    rd(0, 15'h0020);
    op(0, 1'b1, 1'b1, 1'b1, 1'b1, 2'b00, 15'h0000, 16'h0000);
    wr(0, 15'h0020, 16'h6996);
    wr(0, 15'h0020, 16'h6996);
    rd(0, 15'h0020);
    look(0, 1, 16'h6996);
    $display("test cross port done");
    @(posedge clk_in);
    sel[1] <= 1'b0;
    @(posedge clk_in);
    sel[1] <= 1'b1;
    #1 chk(oe[1], 16'h0000);
    chk(sb[1], 1'b1);
    @(posedge clk_in);
    #1 chk(oe[1], 16'h0000);
    @(posedge clk_in);
    #1 chk(oe[1], 16'h0000);
    @(posedge clk_in);
    #1 chk(oe[1], 16'hFFFF);
    @(posedge clk_in);
    oen[0] <= 1'b1;
    #1 chk(oe[0], 16'h0000);
    $display("test select done");
    axi_wr({20'h0, `DPR_CTRL_OFFSET}, 32'h0000_0002);
    chk(r, `DPR_RESP_OKAY);
    wr(0, 15'h0014, 16'h7777);
    op(0, 1'b1, 1'b1, 1'b1, 1'b1, 2'b00, 15'h0000, 16'h0000);
    #1 chk(oe[0], 16'h0000);
    chk(sb[0], 1'b1);
    axi_wr({20'h0, `DPR_CTRL_OFFSET}, 32'h0000_0003);
    rd(0, 15'h0014);
    look(0, 1, 16'h5A5A);
    $display("test port enable done");
    @(posedge clk_in);
    ce <= 1'b0;
    rd(0, 15'h000A);
    look(0, 1, 16'h5A5A);
    @(posedge clk_in);
    ce <= 1'b1;
    $display("test clock enable done");
    end_sim;
  end
  initial begin
    repeat (5000) @(posedge clk_in);
    fail_count++;
    end_sim;
  end
endmodule
`default_nettype wire
